/* src/didc_consts.vh */
// Functional notes
// - Fixed reference threshold: ref times (code-38)/5
// - Open fault when input current below 0.35mA
// - Short enable adds 4mA sink, flags overcurrent
// - Faults set alert status and alert pin
// - Invert select inverts debounced comparator output
// - Count debounced edges, polarity follows inversion
// - Edge counter clears to zero on reset
// - Edge counter rolls over at full scale
// - Counter disabled holds value, ignores edges
// - Direct path selects output stage pin comparator
// - Five-bit debounce time, zero bypasses debouncer
// - Debounce mode bit, mode zero default
// - Mode zero counts up differing, down matching
// - Mode zero reverses direction, clears count only on output change
// - Sample comparator every 800 ns tick
// - Mode one counts change, toggles, then clears
// - Mode one clears count on matching sample
// - General pin drives debounced output when configured
// - Converter defaults to 0 to 12 V range
// - Threshold code seven bits, maximum 98
// - Threshold mode selects supply or fixed reference
`ifndef DIDC_CONSTS_VH
`define DIDC_CONSTS_VH
`define DIDC_ADR_SETUP_ONE   8'h00
`define DIDC_ADR_SETUP_TWO   8'h04
`define DIDC_ADR_COMP_OUT    8'h08
`define DIDC_ADR_COUNTER     8'h0c
`define DIDC_ADR_ALERT       8'h10
`define DIDC_ADR_PIN_SETUP   8'h14
`define DIDC_ADR_ADC_SETUP   8'h18
// Setup one fields.
`define DIDC_F_DEB_LSB       0
`define DIDC_F_DEB_MSB       4
`define DIDC_F_DEB_MODE      5
`define DIDC_F_SINK_LSB      6
`define DIDC_F_SINK_MSB      10
`define DIDC_F_RANGE         11
`define DIDC_F_INVERT        12
`define DIDC_F_COUNT_EN      13
`define DIDC_F_OPEN_EN       14
`define DIDC_F_SHORT_EN      15
// Setup two fields.
`define DIDC_F_THR_LSB       0
`define DIDC_F_THR_MSB       6
`define DIDC_F_THR_REF       7
`define DIDC_F_DIRECT        8
`define DIDC_THR_MAX         7'h62
`define DIDC_THR_FIX_OFS     8'h26
`define DIDC_THR_FIX_DIV     8'h05
`define DIDC_THR_SUP_OFS     8'h30
`define DIDC_THR_SUP_DIV     8'h32
// Pin setup value that routes the debounced output to the pin.
`define DIDC_PIN_DEBOUNCED   3'h1
// Converter range code after reset, 0 to 12 V.
`define DIDC_ADC_RANGE_RST   3'h0
`define DIDC_SETUP_ONE_RST   16'h0000
`define DIDC_SETUP_TWO_RST   16'h0000
`define DIDC_PIN_SETUP_RST   3'h0
`define DIDC_ALERT_RST       2'h0
`define DIDC_SAMPLE_NS       800
`define DIDC_CLK_MHZ         25
`define DIDC_SAMPLE_CYC      ((`DIDC_SAMPLE_NS * `DIDC_CLK_MHZ) / 1000)
`endif

/* src/didc_top.v */
// Local design decisions: the placing of the registers and the Wishbone register port.
`timescale 1ns/1ps
`include "didc_consts.vh"
module didc_top #(
  parameter CNT_W = 16
) (
  input  wire             clk_i,
  input  wire             rst_i,
  input  wire [31:0]      wb_adr_i,
  input  wire [31:0]      wb_dat_i,
  input  wire [3:0]       wb_sel_i,
  input  wire             wb_we_i,
  input  wire             wb_cyc_i,
  input  wire             wb_stb_i,
  output wire [31:0]      wb_dat_o,
  output wire             wb_ack_o,
  output wire             wb_err_o,
  input  wire             comp_sense_i,
  input  wire             comp_direct_i,
  input  wire             open_detect_i,
  input  wire             short_detect_i,
  output wire             direct_path_enable_o,
  output wire [6:0]       threshold_code_o,
  output wire             threshold_ref_select_o,
  output wire [4:0]       sink_code_o,
  output wire             sink_range_o,
  output wire             extra_sink_o,
  output wire             general_pin_o,
  output wire             alert_n_o,
  output wire [2:0]       adc_range_o
);
  localparam SCW = 5;
  localparam integer SAMPLE_TC_I = `DIDC_SAMPLE_CYC - 1;
  localparam [SCW-1:0] SAMPLE_TC = SAMPLE_TC_I[SCW-1:0];

  reg  [15:0]      setup_one_reg;
  reg  [15:0]      setup_two_reg;
  reg  [2:0]       pin_setup_reg;
  reg  [2:0]       adc_range_reg;
  reg  [1:0]       alert_reg;
  reg  [CNT_W-1:0] count_reg;
  reg  [31:0]      dat_reg;
  reg              ack_reg;
  reg              err_reg;
  reg  [SCW-1:0]   tick_cnt_reg;
  reg              tick_reg;
  reg  [2:0]       cs_sync_reg;
  reg  [2:0]       cd_sync_reg;
  reg  [2:0]       oc_sync_reg;
  reg  [2:0]       sc_sync_reg;
  reg              cs_reg;
  reg              cd_reg;
  reg              oc_reg;
  reg              sc_reg;
  reg              deb_reg;
  reg              deb_prev_reg;
  reg  [15:0]      deb_cnt_reg;
  reg              gpin_reg;
  reg              alert_n_reg;
  reg  [31:0]      rd_next;
  reg              hit_next;

  wire [4:0]  deb_code  = setup_one_reg[`DIDC_F_DEB_MSB:`DIDC_F_DEB_LSB];
  wire        deb_mode  = setup_one_reg[`DIDC_F_DEB_MODE];
  wire        inv_sel   = setup_one_reg[`DIDC_F_INVERT];
  wire        cnt_en    = setup_one_reg[`DIDC_F_COUNT_EN];
  wire        open_en   = setup_one_reg[`DIDC_F_OPEN_EN];
  wire        short_en  = setup_one_reg[`DIDC_F_SHORT_EN];
  wire        direct_en = setup_two_reg[`DIDC_F_DIRECT];
  wire        req       = wb_cyc_i & wb_stb_i & ~ack_reg & ~err_reg;
  wire [7:0]  adr       = wb_adr_i[7:0];
  wire        wr_req    = req & wb_we_i;
  wire        rd_req    = req & ~wb_we_i;
  wire        alert_wr  = wr_req & wb_sel_i[0] & (adr == `DIDC_ADR_ALERT);
  wire [15:0] two_wdat  = merge16(setup_two_reg, wb_dat_i, wb_sel_i);
  wire        comp_raw  = direct_en ? cd_reg : cs_reg;
  wire [15:0] target    = deb_target(deb_code);
  wire        comp_out  = deb_reg ^ inv_sel;
  wire        prev_out  = deb_prev_reg ^ inv_sel;
  wire        cnt_edge  = comp_out & ~prev_out & (deb_reg != deb_prev_reg);

  // Debounce code to sample count; counts scale roughly geometrically.
  function [15:0] deb_target;
    input [4:0] code;
    begin
      case (code)
        5'h00: deb_target = 16'h0000;
        5'h01: deb_target = 16'h0001;
        5'h02: deb_target = 16'h0002;
        5'h03: deb_target = 16'h0003;
        5'h04: deb_target = 16'h0004;
        5'h05: deb_target = 16'h0006;
        5'h06: deb_target = 16'h0008;
        5'h07: deb_target = 16'h000b;
        5'h08: deb_target = 16'h0010;
        5'h09: deb_target = 16'h0016;
        5'h0a: deb_target = 16'h0020;
        5'h0b: deb_target = 16'h002d;
        5'h0c: deb_target = 16'h0040;
        5'h0d: deb_target = 16'h005a;
        5'h0e: deb_target = 16'h0080;
        5'h0f: deb_target = 16'h00b5;
        5'h10: deb_target = 16'h0100;
        5'h11: deb_target = 16'h016a;
        5'h12: deb_target = 16'h0200;
        5'h13: deb_target = 16'h02d4;
        5'h14: deb_target = 16'h0400;
        5'h15: deb_target = 16'h05a8;
        5'h16: deb_target = 16'h0800;
        5'h17: deb_target = 16'h0b50;
        5'h18: deb_target = 16'h1000;
        5'h19: deb_target = 16'h16a0;
        5'h1a: deb_target = 16'h2000;
        5'h1b: deb_target = 16'h2d41;
        5'h1c: deb_target = 16'h4000;
        5'h1d: deb_target = 16'h5a82;
        5'h1e: deb_target = 16'h8000;
        default: deb_target = 16'hffff;
      endcase
    end
  endfunction

  // Merge a 16-bit write through its two low byte enables.
  function [15:0] merge16;
    input [15:0] old;
    input [31:0] dat;
    input [3:0]  sel;
    begin
      merge16 = {sel[1] ? dat[15:8] : old[15:8],
                 sel[0] ? dat[7:0]  : old[7:0]};
    end
  endfunction

  // Target reached once this sample would complete the count.
  function deb_done;
    input [15:0] cnt;
    input [15:0] tgt;
    begin
      deb_done = ({1'b0, cnt} + 17'h00001) >= {1'b0, tgt};
    end
  endfunction

  // Synchroniser output follows stage three only while two and three
  // agree, so a level caught mid-change waits one more cycle.
  function sync_agree;
    input [2:0] stages;
    input       held;
    begin
      sync_agree = (stages[1] == stages[2]) ? stages[2] : held;
    end
  endfunction

  // Three-stage synchronisers; a change counts once stages two and three
  // agree, so the first stage feeds nothing but the second.
  // Reset parks every stage low, the idle level of the comparator pins.
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cs_sync_reg <= 3'h0;
      cd_sync_reg <= 3'h0;
      oc_sync_reg <= 3'h0;
      sc_sync_reg <= 3'h0;
      cs_reg      <= 1'b0;
      cd_reg      <= 1'b0;
      oc_reg      <= 1'b0;
      sc_reg      <= 1'b0;
    end
    else
    begin
      cs_sync_reg <= {cs_sync_reg[1:0], comp_sense_i};
      cd_sync_reg <= {cd_sync_reg[1:0], comp_direct_i};
      oc_sync_reg <= {oc_sync_reg[1:0], open_detect_i};
      sc_sync_reg <= {sc_sync_reg[1:0], short_detect_i};
      cs_reg      <= sync_agree(cs_sync_reg, cs_reg);
      cd_reg      <= sync_agree(cd_sync_reg, cd_reg);
      oc_reg      <= sync_agree(oc_sync_reg, oc_reg);
      sc_reg      <= sync_agree(sc_sync_reg, sc_reg);
    end
  end

  // Sample tick every 800 ns, twenty cycles at 25 MHz.
  // The tick runs free, so a change may wait up to one period to be seen.
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      tick_cnt_reg <= {SCW{1'b0}};
      tick_reg     <= 1'b0;
    end
    else if (tick_cnt_reg == SAMPLE_TC)
    begin
      tick_cnt_reg <= {SCW{1'b0}};
      tick_reg     <= 1'b1;
    end
    else
    begin
      tick_cnt_reg <= tick_cnt_reg + 1'b1;
      tick_reg     <= 1'b0;
    end
  end

  // Debouncer. Mode 0 integrates: up while the sample differs, down while
  // it matches, so brief glitches cost time instead of restarting.
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      deb_reg     <= 1'b0;
      deb_cnt_reg <= 16'h0000;
    end
    else if (tick_reg)
    begin
      if (deb_code == 5'h00)
      begin
        deb_reg     <= comp_raw;
        deb_cnt_reg <= 16'h0000;
      end
      else if (deb_mode == 1'b0)
      begin
        if (comp_raw != deb_reg)
        begin
          if (deb_done(deb_cnt_reg, target))
          begin
            deb_reg     <= comp_raw;
            deb_cnt_reg <= 16'h0000;
          end
          else
            deb_cnt_reg <= deb_cnt_reg + 16'h0001;
        end
        else if (deb_cnt_reg != 16'h0000)
          deb_cnt_reg <= deb_cnt_reg - 16'h0001;
      end
      else
      begin
        // Any matching sample restarts mode 1, so a change must hold.
        if (comp_raw == deb_reg)
          deb_cnt_reg <= 16'h0000;
        else if (deb_done(deb_cnt_reg, target))
        begin
          deb_reg     <= ~deb_reg;
          deb_cnt_reg <= 16'h0000;
        end
        else
          deb_cnt_reg <= deb_cnt_reg + 16'h0001;
      end
    end
  end

  // Edge counter on the inverted-or-not output: rising edges of it are
  // rising or falling raw edges depending on the invert bit.
  // Only CNT_W bits wide: software must read it before it wraps.
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      deb_prev_reg <= 1'b0;
      count_reg    <= {CNT_W{1'b0}};
    end
    else
    begin
      deb_prev_reg <= deb_reg;
      if (cnt_en && cnt_edge)
        count_reg <= count_reg + 1'b1;
    end
  end

  // Wishbone slave, one wait state: ack one cycle after the strobe.
  // Unmapped addresses answer with err and change nothing.
  always @*
  begin
    rd_next  = 32'h0000_0000;
    hit_next = 1'b1;
    case (adr)
      `DIDC_ADR_SETUP_ONE: rd_next = {16'h0000, setup_one_reg};
      `DIDC_ADR_SETUP_TWO: rd_next = {16'h0000, setup_two_reg};
      `DIDC_ADR_COMP_OUT:  rd_next = {31'h0, comp_out};
      `DIDC_ADR_COUNTER:   rd_next = {{(32-CNT_W){1'b0}}, count_reg};
      `DIDC_ADR_ALERT:     rd_next = {30'h0, alert_reg};
      `DIDC_ADR_PIN_SETUP: rd_next = {29'h0, pin_setup_reg};
      `DIDC_ADR_ADC_SETUP: rd_next = {29'h0, adc_range_reg};
      default:             hit_next = 1'b0;
    endcase
  end

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      setup_one_reg <= `DIDC_SETUP_ONE_RST;
      setup_two_reg <= `DIDC_SETUP_TWO_RST;
      pin_setup_reg <= `DIDC_PIN_SETUP_RST;
      adc_range_reg <= `DIDC_ADC_RANGE_RST;
      dat_reg       <= 32'h0000_0000;
      ack_reg       <= 1'b0;
      err_reg       <= 1'b0;
    end
    else
    begin
      ack_reg <= req & hit_next;
      err_reg <= req & ~hit_next;
      // Read data stays zero outside the ack cycle.
      dat_reg <= (rd_req & hit_next) ? rd_next : 32'h0000_0000;
      if (wr_req)
      begin
        case (adr)
          `DIDC_ADR_SETUP_ONE:
            setup_one_reg <= merge16(setup_one_reg, wb_dat_i, wb_sel_i);
          `DIDC_ADR_SETUP_TWO:
          begin
            setup_two_reg[15:7] <= two_wdat[15:7];
            // Codes above the maximum are clamped, not stored raw.
            if (wb_sel_i[0])
              setup_two_reg[6:0] <= (wb_dat_i[6:0] > `DIDC_THR_MAX) ?
                                    `DIDC_THR_MAX : wb_dat_i[6:0];
          end
          `DIDC_ADR_PIN_SETUP:
            if (wb_sel_i[0])
              pin_setup_reg <= wb_dat_i[2:0];
          `DIDC_ADR_ADC_SETUP:
            if (wb_sel_i[0])
              adc_range_reg <= wb_dat_i[2:0];
          default:
            ;
        endcase
      end
    end
  end

  // Faults are sticky; a new fault wins over a write-one clear, so a fault
  // that is still present is never lost to a clear in the same cycle.
  always @(posedge clk_i)
  begin
    if (rst_i)
      alert_reg <= `DIDC_ALERT_RST;
    else
    begin
      alert_reg[0] <= (open_en & oc_reg) |
                      (alert_reg[0] & ~(alert_wr & wb_dat_i[0]));
      alert_reg[1] <= (short_en & sc_reg) |
                      (alert_reg[1] & ~(alert_wr & wb_dat_i[1]));
    end
  end

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      gpin_reg    <= 1'b0;
      alert_n_reg <= 1'b1;
    end
    else
    begin
      gpin_reg    <= (pin_setup_reg == `DIDC_PIN_DEBOUNCED) & comp_out;
      alert_n_reg <= ~(|alert_reg);
    end
  end

  // The analog threshold DAC does the scaling; code and reference choice
  // go out unchanged.
  // Every output is a register bit, so none of them can glitch.
  assign threshold_code_o       = setup_two_reg[`DIDC_F_THR_MSB:`DIDC_F_THR_LSB];
  assign threshold_ref_select_o = setup_two_reg[`DIDC_F_THR_REF];
  assign direct_path_enable_o   = direct_en;
  assign sink_code_o  = setup_one_reg[`DIDC_F_SINK_MSB:`DIDC_F_SINK_LSB];
  assign sink_range_o = setup_one_reg[`DIDC_F_RANGE];
  assign extra_sink_o = short_en;
  assign general_pin_o = gpin_reg;
  assign alert_n_o     = alert_n_reg;
  assign adc_range_o   = adc_range_reg;
  assign wb_dat_o      = dat_reg;
  assign wb_ack_o      = ack_reg;
  assign wb_err_o      = err_reg;
endmodule // didc_top

/* verification/didc_sensor_model.sv */
`timescale 1ns/1ps
module didc_sensor_model (
  input  wire        level_i,
  input  wire        path_i,
  input  wire [15:0] cur_ua_i,
  output wire        sense_o,
  output wire        direct_o,
  output wire        open_o,
  output wire        short_o
);
  // The unused path shows the inverse level, so a wrong choice shows.
  assign sense_o  = level_i ^ path_i;
  assign direct_o = level_i ^ ~path_i;
  assign open_o   = cur_ua_i < 16'h015e;
  assign short_o  = cur_ua_i > 16'h0fa0;
endmodule // didc_sensor_model

/* verification/didc_top_asserts.sv */
`timescale 1ns/1ps
module didc_top_checker #(
  parameter CNT_W = 16
) (
  input wire        clk_i,
  input wire        rst_i,
  input wire        wb_we_i,
  input wire        wb_cyc_i,
  input wire        wb_stb_i,
  input wire [31:0] wb_dat_o,
  input wire        wb_ack_o,
  input wire        wb_err_o,
  input wire        direct_path_enable_o,
  input wire [6:0]  threshold_code_o,
  input wire        threshold_ref_select_o,
  input wire        extra_sink_o,
  input wire        alert_n_o,
  input wire [2:0]  adc_range_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
  bus_answer_a: assert property (req |=> wb_ack_o ^ wb_err_o)
    else $error("bus request not answered");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  data_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  thr_limit_a: assert property (threshold_code_o <= 7'h62)
    else $error("threshold code above limit");
  thr_hold_a: assert property ($changed(threshold_code_o) |->
    wb_ack_o || $past(wb_ack_o)) else $error("threshold moved alone");
  ref_hold_a: assert property ($changed(threshold_ref_select_o) |->
    wb_ack_o || $past(wb_ack_o)) else $error("reference moved alone");
  path_hold_a: assert property ($changed(direct_path_enable_o) |->
    wb_ack_o || $past(wb_ack_o)) else $error("path moved alone");
  sink_extra_a: assert property ($changed(extra_sink_o) |->
    wb_ack_o || $past(wb_ack_o)) else $error("extra sink moved alone");
  range_hold_a: assert property ($changed(adc_range_o) |->
    wb_ack_o || $past(wb_ack_o)) else $error("range moved alone");
  alert_clear_a: assert property ($rose(alert_n_o) |-> $past(wb_ack_o) ||
    $past(wb_ack_o, 2) || $past(wb_ack_o, 3)) else $error("alert left alone");
endmodule // didc_top_checker
bind didc_top didc_top_checker #(.CNT_W(CNT_W)) didc_top_checker_inst (
  .clk_i(clk_i), .rst_i(rst_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .wb_err_o(wb_err_o), .direct_path_enable_o(direct_path_enable_o),
  .threshold_code_o(threshold_code_o), .extra_sink_o(extra_sink_o),
  .threshold_ref_select_o(threshold_ref_select_o), .alert_n_o(alert_n_o),
  .adc_range_o(adc_range_o));

/* verification/didc_top_tb.sv */
`timescale 1ns/1ps
module didc_top_tb;
  localparam CW = 4;
  logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, lvl = 0, path = 0;
  logic [31:0] adr = 0, wdat = 0;
  logic [3:0] sel = 0;
  logic [15:0] cur = 16'h03e8;
  logic [15:0] s1[3] = '{16'h0500, 16'h0f40, 16'hc3c0};
  logic [6:0] rc;
  logic [32:0] q[$];
  wire sense, direct, open_f, short_f, ack, err, alert_n, gpin, dpe, trs;
  wire srng, xsink;
  wire [31:0] rdat;
  wire [6:0] thr;
  wire [4:0] sink;
  wire [2:0] arng;
  int failures = 0, n_compared = 0, seed = 32'ha5fe, cnt = 0, i, r;
  always #20 clk_i = ~clk_i;
  didc_top #(.CNT_W(CW)) didc_top_inst (.clk_i(clk_i), .rst_i(rst_i),
    .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel), .wb_we_i(we),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(rdat), .wb_ack_o(ack),
    .wb_err_o(err), .comp_sense_i(sense), .comp_direct_i(direct),
    .open_detect_i(open_f), .short_detect_i(short_f),
    .direct_path_enable_o(dpe), .threshold_code_o(thr),
    .threshold_ref_select_o(trs), .sink_code_o(sink), .sink_range_o(srng),
    .extra_sink_o(xsink), .general_pin_o(gpin), .alert_n_o(alert_n),
    .adc_range_o(arng));
  didc_sensor_model didc_sensor_model_inst (.level_i(lvl), .path_i(path),
    .cur_ua_i(cur), .sense_o(sense), .direct_o(direct), .open_o(open_f),
    .short_o(short_f));
  task check(input logic [32:0] got, input logic [32:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task chk1(input logic g, input logic e);
    check({32'h0, g}, {32'h0, e});
  endtask
  task results;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= {24'h0, a};
    wdat <= d;
    sel <= 4'h3;
    @(posedge clk_i);
    while (ack !== 1'b1 && err !== 1'b1) @(posedge clk_i);
    cyc <= 0;
    stb <= 0;
    we <= 0;
    @(posedge clk_i);
  endtask
  task rd(input logic [7:0] a, input logic [32:0] e);
    q.push_back(e);
    wb(0, a, 0);
  endtask
  task hold(input logic v, input int n);
    lvl <= v;
    repeat (n) @(posedge clk_i);
  endtask
  task pulses(input int n);
    repeat (n)
    begin
      hold(1, 60);
      hold(0, 60);
    end
  endtask
  always @(negedge clk_i)
    if ((ack === 1'b1 || err === 1'b1) && we === 1'b0)
      check({err, rdat}, q.size() ? q.pop_front() : 33'h1ffffffff);
  initial
  begin
    #2000000;
    failures++;
    results();
  end
  initial
  begin
    repeat (20) @(posedge clk_i);
    rst_i <= 0;
    @(posedge clk_i);
    for (i = 0; i < 7; i++)
      rd(i * 4, 33'h0);
    rd(8'h1c, 33'h100000000);
    chk1(alert_n, 1'b1);
    check({30'h0, arng}, 33'h0);
    $display("reset test done");
    rc = {$random(seed)} % 99;
    wb(1, 8'h04, 32'h0ff);
    rd(8'h04, 33'h0e2);
    wb(1, 8'h04, {25'h0, rc});
    check({26'h0, thr}, {26'h0, rc});
    for (i = 0; i < 3; i++)
    begin
      wb(1, 8'h00, {16'h0, s1[i]});
      wb(1, 8'h04, 32'h0b7);
      check({18'h0, xsink, srng, sink, trs, thr}, {18'h0, s1[i][15], s1[i][11], s1[i][10:6], 8'hb7});
    end
    $display("setup test done");
    wb(1, 8'h00, 32'h2000);
    hold(0, 100);
    r = {$random(seed)} % 4 + 2;
    pulses(r);
    cnt += r;
    rd(8'h0c, cnt % 16);
    rd(8'h08, 33'h0);
    wb(1, 8'h00, 32'h3000);
    hold(0, 60);
    rd(8'h08, 33'h1);
    rd(8'h0c, cnt % 16);
    pulses(15);
    cnt += 15;
    rd(8'h0c, cnt % 16);
    wb(1, 8'h00, 32'h1000);
    pulses(2);
    rd(8'h0c, cnt % 16);
    $display("counter test done");
    for (i = 0; i < 2; i++)
    begin
      wb(1, 8'h00, i * 32 + 3);
      hold(0, 100);
      hold(1, 40);
      hold(0, 20);
      hold(1, 40);
      hold(0, 25);
      rd(8'h08, {32'h0, i == 0});
    end
    $display("debounce test done");
    wb(1, 8'h00, 32'h0);
    wb(1, 8'h04, 32'h100);
    chk1(dpe, 1'b1);
    path <= 1;
    hold(1, 80);
    rd(8'h08, 33'h1);
    wb(1, 8'h14, 32'h1);
    repeat (3) @(posedge clk_i);
    chk1(gpin, 1'b1);
    wb(1, 8'h14, 32'h2);
    repeat (3) @(posedge clk_i);
    chk1(gpin, 1'b0);
    path <= 0;
    wb(1, 8'h04, 32'h0);
    chk1(dpe, 1'b0);
    hold(0, 80);
    $display("output test done");
    cur <= 16'h0064;
    wb(1, 8'h00, 32'h4000);
    repeat (10) @(posedge clk_i);
    chk1(alert_n, 1'b0);
    rd(8'h10, 33'h1);
    cur <= 16'h1388;
    repeat (10) @(posedge clk_i);
    wb(1, 8'h00, 32'hc000);
    wb(1, 8'h10, 32'h3);
    repeat (10) @(posedge clk_i);
    rd(8'h10, 33'h2);
    cur <= 16'h03e8;
    repeat (10) @(posedge clk_i);
    wb(1, 8'h10, 32'h3);
    repeat (10) @(posedge clk_i);
    rd(8'h10, 33'h0);
    chk1(alert_n, 1'b1);
    $display("alert test done");
    rc = $random(seed);
    wb(1, 8'h18, {29'h0, rc[2:0]});
    check({30'h0, arng}, {30'h0, rc[2:0]});
    rd(8'h18, {30'h0, rc[2:0]});
    wb(1, 8'h08, 32'h1);
    rd(8'h08, 33'h0);
    rst_i <= 1;
    repeat (2) @(posedge clk_i);
    rst_i <= 0;
    @(posedge clk_i);
    rd(8'h0c, 33'h0);
    $display("register test done");
    results();
  end
endmodule // didc_top_tb
